/* File: hdl/gcs_gain_sense_cfg.sv */
// Top: gain-control limits, reduction order, carrier sense and clear channel
//
// Operation
// [RL1] Digital ceiling code removes top digital steps
// [RL2] Front-amp ceiling field, reset zero, caps gain
// [RL3] Front-amp codes 1-7 cut 2.6 to 17.1 dB
// [RL4] Setpoint code selects 24..42 dB target
// [RL5] Order bit picks which amplifier reduces first
// [RL6] Relative step: off, or 6/10/14 dB rise
// [RL7] Absolute level is signed dB from setpoint
// [RL8] Absolute code -8 disables absolute detection
// [RL9] Mode 01: clear only while RSSI below threshold
// [RL10] Reserved top sense bit reads zero, unwritable
`timescale 1ns/1ps
module gcs_gain_sense_cfg #(
   parameter int DIG_STEPS = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [5:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   input wire logic signed [7:0] i_rssi,
   input wire logic i_rssi_valid,
   input wire logic [1:0] i_channel_clear_select,
   input wire logic i_rx_packet_active,
   input wire logic i_reduce_req,
   input wire logic i_stage1_at_min,
   input wire logic i_stage2_at_min,
   output logic [3:0] o_digital_gain_top_step,
   output logic [2:0] o_front_amp_gain_ceiling,
   output logic [7:0] o_front_amp_atten_tenth_db,
   output logic signed [7:0] o_amplitude_setpoint_db,
   output logic o_reduce_stage1,
   output logic o_reduce_stage2,
   output logic o_carrier_sense,
   output logic o_channel_clear
);

   gcs_pkg::gcs_limit_t limit_reg;
   gcs_pkg::gcs_sense_t sense_reg;
   logic sense_now;

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   // Writes land on the next edge; the reserved bit is never stored
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         limit_reg <= gcs_pkg::GAIN_LIMIT_TARGET_CFG_RST; // RL2
         sense_reg <= gcs_pkg::GAIN_ORDER_SENSE_CFG_RST;
      end else if (i_reg_wr) begin
         if (i_reg_addr == gcs_pkg::GAIN_LIMIT_TARGET_CFG_OFS) begin
            limit_reg <= i_reg_wdata;
         end
         if (i_reg_addr == gcs_pkg::GAIN_ORDER_SENSE_CFG_OFS) begin
            sense_reg <= i_reg_wdata & gcs_pkg::RESERVED_MASK; // RL10
         end
      end
   end

   // Read data registered, one cycle after the read strobe
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_reg_rdata <= gcs_pkg::UNMAPPED_RDATA;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            gcs_pkg::GAIN_LIMIT_TARGET_CFG_OFS: o_reg_rdata <= limit_reg;
            gcs_pkg::GAIN_ORDER_SENSE_CFG_OFS: o_reg_rdata <= sense_reg & gcs_pkg::RESERVED_MASK; // RL10
            default: o_reg_rdata <= gcs_pkg::UNMAPPED_RDATA;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Gain limit decode
   // ---------------------------------------------------------------
   // Registered so the gain loop sees a glitch-free limit
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_digital_gain_top_step <= 4'(DIG_STEPS - 1);
         o_front_amp_gain_ceiling <= 3'h0;
         o_front_amp_atten_tenth_db <= 8'h00;
         o_amplitude_setpoint_db <= gcs_pkg::setpoint_db(3'h3);
      end else begin
         o_digital_gain_top_step <= 4'(DIG_STEPS - 1) - 4'(limit_reg.digital_gain_ceiling); // RL1
         o_front_amp_gain_ceiling <= limit_reg.front_amp_gain_ceiling; // RL2
         o_front_amp_atten_tenth_db <=
            gcs_pkg::front_atten_tenth_db(limit_reg.front_amp_gain_ceiling); // RL3
         o_amplitude_setpoint_db <= gcs_pkg::setpoint_db(limit_reg.amplitude_setpoint); // RL4
      end
   end

   // ---------------------------------------------------------------
   // Gain reduction order
   // ---------------------------------------------------------------
   // One-cycle step request; a stage already at minimum hands over
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_reduce_stage1 <= 1'b0;
         o_reduce_stage2 <= 1'b0;
      end else if (!i_reduce_req) begin
         o_reduce_stage1 <= 1'b0;
         o_reduce_stage2 <= 1'b0;
      end else if (sense_reg.gain_reduction_order) begin
         o_reduce_stage1 <= !i_stage1_at_min; // RL5
         o_reduce_stage2 <= i_stage1_at_min && !i_stage2_at_min;
      end else begin
         o_reduce_stage2 <= !i_stage2_at_min; // RL5
         o_reduce_stage1 <= i_stage2_at_min && !i_stage1_at_min;
      end
   end

   // ---------------------------------------------------------------
   // Carrier sense
   // ---------------------------------------------------------------
   gcs_sense_detect u_sense (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_rssi(i_rssi),
      .i_rssi_valid(i_rssi_valid),
      .i_setpoint_db(gcs_pkg::setpoint_db(limit_reg.amplitude_setpoint)),
      .i_relative_sense_step(sense_reg.relative_sense_step),
      .i_absolute_sense_level(sense_reg.absolute_sense_level),
      .o_carrier_sense(sense_now)
   );

   // Output copy keeps the top output on its own flop
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_carrier_sense <= 1'b0;
      end else begin
         o_carrier_sense <= sense_now;
      end
   end

   // Clear-channel decision, one cycle behind the sense flag
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_channel_clear <= 1'b1;
      end else begin
         case (i_channel_clear_select)
            gcs_pkg::CLEAR_ALWAYS: o_channel_clear <= 1'b1;
            gcs_pkg::CLEAR_RSSI: o_channel_clear <= !sense_now; // RL9
            gcs_pkg::CLEAR_NOT_RX: o_channel_clear <= !i_rx_packet_active;
            default: o_channel_clear <= !sense_now && !i_rx_packet_active;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // One clock domain, so one default clock and reset serve every property
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   // Register file and gain limits; decoded outputs trail a write by two edges
   dig_ceiling_a: assert property ( // RL1
      i_reg_wr && i_reg_addr == gcs_pkg::GAIN_LIMIT_TARGET_CFG_OFS
      |=> ##1 o_digital_gain_top_step == 4'(DIG_STEPS - 1) - 4'($past(i_reg_wdata[7:6], 2)))
      else $error("digital gain top step wrong");
   fa_reset_a: assert property ( // RL2
      $rose(!i_rst) |-> o_front_amp_gain_ceiling == 3'h0 && sense_reg.gain_reduction_order)
      else $error("front amp ceiling or order not at reset");
   fa_atten_a: assert property ( // RL3
      limit_reg.front_amp_gain_ceiling == 3'h7 ##1 limit_reg.front_amp_gain_ceiling == 3'h7
      |-> o_front_amp_atten_tenth_db == 8'hab)
      else $error("front amp cut for top code wrong");
   setpoint_map_a: assert property ( // RL4
      (limit_reg.amplitude_setpoint == 3'h0) [*2] |-> o_amplitude_setpoint_db == 8'sh18)
      else $error("setpoint for code 0 wrong");
   rsvd_store_a: assert property ( // RL10
      !sense_reg.reserved)
      else $error("reserved bit stored");
   rsvd_zero_a: assert property ( // RL10
      i_reg_rd |=> !o_reg_rdata[7] || $past(i_reg_addr) != gcs_pkg::GAIN_ORDER_SENSE_CFG_OFS)
      else $error("reserved bit read as one");

   // Reduction order: pulse one edge after the request, never both stages
   order_pick_a: assert property ( // RL5
      i_reduce_req && !sense_reg.gain_reduction_order && !i_stage2_at_min
      |=> o_reduce_stage2 && !o_reduce_stage1)
      else $error("second stage not reduced first");
   order_first_a: assert property ( // RL5
      i_reduce_req && sense_reg.gain_reduction_order && !i_stage1_at_min
      |=> o_reduce_stage1 && !o_reduce_stage2)
      else $error("first stage not reduced first");
   floor_idle_a: assert property ( // RL5
      i_reduce_req && i_stage1_at_min && i_stage2_at_min
      |=> !o_reduce_stage1 && !o_reduce_stage2)
      else $error("reduction pulse with both stages at minimum");

   // Carrier sense; the relative test measures from the last idle sample
   rel_rise_a: assert property ( // RL6
      i_rssi_valid && !sense_now && sense_reg.relative_sense_step == 2'h1
      ##1 i_rssi_valid && sense_reg.relative_sense_step == 2'h1
      && i_rssi >= $past(i_rssi) + 8'sd6 && $past(i_rssi) < 8'sh70
      |=> sense_now ##1 o_carrier_sense)
      else $error("relative rise not sensed");
   sense_hold_a: assert property ( // RL6
      !i_rssi_valid |=> $stable(sense_now))
      else $error("sense changed without a sample");
   abs_level_a: assert property ( // RL7
      i_rssi_valid && sense_reg.absolute_sense_level == 4'h0
      && i_rssi >= gcs_pkg::setpoint_db(limit_reg.amplitude_setpoint) |=> sense_now)
      else $error("absolute level not sensed");
   both_off_a: assert property ( // RL8
      sense_reg.absolute_sense_level == gcs_pkg::ABS_LEVEL_OFF
      && sense_reg.relative_sense_step == 2'h0 && i_rssi_valid |=> !sense_now)
      else $error("sense with both detectors off");

   // Clear channel follows the selection one edge later
   clear_always_a: assert property ( // RL9
      i_channel_clear_select == gcs_pkg::CLEAR_ALWAYS |=> o_channel_clear)
      else $error("channel not clear in always mode");
   clear_rssi_a: assert property ( // RL9
      i_channel_clear_select == gcs_pkg::CLEAR_RSSI |=> o_channel_clear == !$past(sense_now))
      else $error("clear channel does not follow rssi");
   clear_rx_a: assert property ( // RL9
      i_channel_clear_select == gcs_pkg::CLEAR_NOT_RX
      |=> o_channel_clear == !$past(i_rx_packet_active))
      else $error("clear channel does not follow receive state");
   clear_both_a: assert property ( // RL9
      i_channel_clear_select == gcs_pkg::CLEAR_BOTH
      |=> o_channel_clear == (!$past(sense_now) && !$past(i_rx_packet_active)))
      else $error("clear channel ignores rssi or receive state");

   // Main scenarios the bench should reach
   sense_seen_c: cover property (o_carrier_sense ##1 !o_carrier_sense);
   busy_rx_c: cover property (i_channel_clear_select == gcs_pkg::CLEAR_BOTH && !o_channel_clear);
   handover_c: cover property (i_reduce_req && i_stage1_at_min ##1 o_reduce_stage2);
   handback_c: cover property (i_reduce_req && i_stage2_at_min ##1 o_reduce_stage1);
   rel_fire_c: cover property (sense_reg.relative_sense_step != 2'h0 && $rose(sense_now));

endmodule // gcs_gain_sense_cfg

/* File: pkg/gcs_pkg.sv */
// Package: register map, field layout and decode tables of the gain/carrier-sense block
package gcs_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [5:0] GAIN_LIMIT_TARGET_CFG_OFS = 6'h1b;
   localparam logic [5:0] GAIN_ORDER_SENSE_CFG_OFS = 6'h1c;
   localparam logic [7:0] GAIN_LIMIT_TARGET_CFG_RST = 8'h03;
   localparam logic [7:0] GAIN_ORDER_SENSE_CFG_RST = 8'h40;
   localparam logic [7:0] RESERVED_MASK = 8'h7f;
   localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

   // ---------------------------------------------------------------
   // Field codes
   // ---------------------------------------------------------------
   localparam logic [3:0] ABS_LEVEL_OFF = 4'h8;
   localparam logic [1:0] REL_STEP_OFF = 2'h0;
   localparam logic [1:0] CLEAR_ALWAYS = 2'h0;
   localparam logic [1:0] CLEAR_RSSI = 2'h1;
   localparam logic [1:0] CLEAR_NOT_RX = 2'h2;
   localparam logic [1:0] CLEAR_BOTH = 2'h3;

   // Gain limit / setpoint register image (msb first)
   typedef struct packed {
      logic [1:0] digital_gain_ceiling;
      logic [2:0] front_amp_gain_ceiling;
      logic [2:0] amplitude_setpoint;
   } gcs_limit_t;

   // Gain order / carrier sense register image (msb first)
   typedef struct packed {
      logic reserved;
      logic gain_reduction_order;
      logic [1:0] relative_sense_step;
      logic [3:0] absolute_sense_level;
   } gcs_sense_t;

   // Averaged channel-filter amplitude target, dB
   function automatic logic signed [7:0] setpoint_db(input logic [2:0] code);
      case (code)
         3'h0: setpoint_db = 8'sh18;
         3'h1: setpoint_db = 8'sh1b;
         3'h2: setpoint_db = 8'sh1e;
         3'h3: setpoint_db = 8'sh21;
         3'h4: setpoint_db = 8'sh24;
         3'h5: setpoint_db = 8'sh26;
         3'h6: setpoint_db = 8'sh28;
         default: setpoint_db = 8'sh2a;
      endcase
   endfunction

   // Front-amplifier cut below full gain, tenths of a dB
   function automatic logic [7:0] front_atten_tenth_db(input logic [2:0] code);
      case (code)
         3'h0: front_atten_tenth_db = 8'h00;
         3'h1: front_atten_tenth_db = 8'h1a;
         3'h2: front_atten_tenth_db = 8'h3d;
         3'h3: front_atten_tenth_db = 8'h4a;
         3'h4: front_atten_tenth_db = 8'h5c;
         3'h5: front_atten_tenth_db = 8'h73;
         3'h6: front_atten_tenth_db = 8'h92;
         default: front_atten_tenth_db = 8'hab;
      endcase
   endfunction

   // Relative carrier-sense rise, dB (0 means disabled)
   function automatic logic signed [8:0] rel_step_db(input logic [1:0] code);
      case (code)
         2'h1: rel_step_db = 9'sh006;
         2'h2: rel_step_db = 9'sh00a;
         2'h3: rel_step_db = 9'sh00e;
         default: rel_step_db = 9'sh000;
      endcase
   endfunction

endpackage

/* File: hdl/gcs_sense_detect.sv */
// Carrier-sense detector: relative rise and absolute level against the setpoint
`timescale 1ns/1ps
module gcs_sense_detect (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic signed [7:0] i_rssi,
   input wire logic i_rssi_valid,
   input wire logic signed [7:0] i_setpoint_db,
   input wire logic [1:0] i_relative_sense_step,
   input wire logic [3:0] i_absolute_sense_level,
   output logic o_carrier_sense
);

   logic signed [7:0] baseline_reg;
   logic signed [8:0] rise;
   logic signed [8:0] abs_thr;
   logic rel_hit;
   logic abs_hit;

   // ---------------------------------------------------------------
   // Threshold compare
   // ---------------------------------------------------------------
   // Nine bits so rssi-baseline and setpoint+offset never wrap
   always_comb begin
      rise = 9'(i_rssi) - 9'(baseline_reg);
      abs_thr = 9'(i_setpoint_db) + 9'($signed(i_absolute_sense_level)); // RL7
      rel_hit = (i_relative_sense_step != gcs_pkg::REL_STEP_OFF) &&
                (rise >= gcs_pkg::rel_step_db(i_relative_sense_step)); // RL6
      abs_hit = (i_absolute_sense_level != gcs_pkg::ABS_LEVEL_OFF) &&
                (9'(i_rssi) >= abs_thr); // RL8
   end

   // Baseline follows RSSI while sense is low, the rising sample too, so a steady rise is sensed for one sample only
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         baseline_reg <= 8'sh7f;
      end else if (i_rssi_valid && !o_carrier_sense) begin
         baseline_reg <= i_rssi;
      end
   end

   // Sense flag updated once per RSSI sample
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_carrier_sense <= 1'b0;
      end else if (i_rssi_valid) begin
         o_carrier_sense <= rel_hit || abs_hit; // RL6 RL7
      end
   end

endmodule // gcs_sense_detect

/* File: dv/gcs_tb.sv */
// Self-checking testbench of the gain-control and carrier-sense configuration block
`timescale 1ns/1ps
module testbench;
   // ----------------------------------------------------------------
   // Signals and design instance
   // ----------------------------------------------------------------
   localparam int DS = 8;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [5:0] i_reg_addr = 6'h00;
   logic [7:0] i_reg_wdata = 8'h00;
   logic signed [7:0] i_rssi = 8'sh00;
   logic i_rssi_valid = 1'b0;
   logic [1:0] i_channel_clear_select = 2'h1;
   logic i_rx_packet_active = 1'b0;
   logic i_reduce_req = 1'b0;
   logic i_stage1_at_min = 1'b0;
   logic i_stage2_at_min = 1'b0;
   logic [7:0] o_reg_rdata;
   logic [3:0] o_digital_gain_top_step;
   logic [2:0] o_front_amp_gain_ceiling;
   logic [7:0] o_front_amp_atten_tenth_db;
   logic signed [7:0] o_amplitude_setpoint_db;
   logic o_reduce_stage1;
   logic o_reduce_stage2;
   logic o_carrier_sense;
   logic o_channel_clear;
   int fails = 0;
   int comparisons = 0;
   gcs_gain_sense_cfg #(.DIG_STEPS(DS)) i_gcs_gain_sense_cfg (.i_sys_clk(i_sys_clk),
      .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_rssi(i_rssi),
      .i_rssi_valid(i_rssi_valid), .i_channel_clear_select(i_channel_clear_select),
      .i_rx_packet_active(i_rx_packet_active), .i_reduce_req(i_reduce_req),
      .i_stage1_at_min(i_stage1_at_min), .i_stage2_at_min(i_stage2_at_min),
      .o_digital_gain_top_step(o_digital_gain_top_step),
      .o_front_amp_gain_ceiling(o_front_amp_gain_ceiling),
      .o_front_amp_atten_tenth_db(o_front_amp_atten_tenth_db),
      .o_amplitude_setpoint_db(o_amplitude_setpoint_db), .o_reduce_stage1(o_reduce_stage1),
      .o_reduce_stage2(o_reduce_stage2), .o_carrier_sense(o_carrier_sense),
      .o_channel_clear(o_channel_clear));
   // 100 MHz clock
   initial begin
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Write strobe is dropped on the taking edge, decoded outputs settle two edges later
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge i_sys_clk) begin i_reg_wr <= 1'b1; i_reg_addr <= a; i_reg_wdata <= d; end
      @(posedge i_sys_clk) i_reg_wr <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(posedge i_sys_clk) begin i_reg_rd <= 1'b1; i_reg_addr <= a; end
      @(posedge i_sys_clk) i_reg_rd <= 1'b0;
      @(posedge i_sys_clk) #1;
      chk("rdata", exp, o_reg_rdata);
   endtask
   // One RSSI sample, then wait for the registered sense and clear flags
   task automatic smp(input logic [7:0] v);
      @(posedge i_sys_clk) begin i_rssi_valid <= 1'b1; i_rssi <= v; end
      @(posedge i_sys_clk) i_rssi_valid <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic stop_test();
      if (fails == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk("top_step", 8'(DS - 1), {4'h0, o_digital_gain_top_step});
      chk("fa_ceiling", 8'h00, {5'h00, o_front_amp_gain_ceiling});
      chk("setpoint", 8'h21, o_amplitude_setpoint_db);
      chk("clear", 8'h01, {7'h00, o_channel_clear});
      rd(6'h1b, 8'h03);
      rd(6'h1c, 8'h40);
      rd(6'h05, 8'h00);
   endtask
   // Every code of the ceiling, setpoint and front-amp fields
   task automatic t_limits();
      logic [7:0] att [8] = '{8'h00, 8'h1a, 8'h3d, 8'h4a, 8'h5c, 8'h73, 8'h92, 8'hab};
      logic [7:0] sp [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
      for (int i = 0; i < 8; i++) begin
         wr(6'h1b, {i[1:0], i[2:0], 3'(7 - i)});
         chk("top_step", 8'(DS - 1 - i % 4), {4'h0, o_digital_gain_top_step});
         chk("fa_ceiling", 8'(i), {5'h00, o_front_amp_gain_ceiling});
         chk("atten", att[i], o_front_amp_atten_tenth_db);
         chk("setpoint", sp[7 - i], o_amplitude_setpoint_db);
         rd(6'h1b, {i[1:0], i[2:0], 3'(7 - i)});
      end
      wr(6'h1c, 8'hff);
      rd(6'h1c, 8'h7f);
   endtask
   // Table of order bit, stage minimum flags and expected pulses
   task automatic t_reduce();
      logic [4:0] tc [6] = '{5'b10010, 5'b11001, 5'b00001, 5'b00110, 5'b11100, 5'b01100};
      for (int i = 0; i < 6; i++) begin
         wr(6'h1c, {1'b0, tc[i][4], 6'h08});
         @(posedge i_sys_clk) begin
            i_reduce_req <= 1'b1;
            i_stage1_at_min <= tc[i][3];
            i_stage2_at_min <= tc[i][2];
         end
         @(posedge i_sys_clk) i_reduce_req <= 1'b0;
         #1;
         chk("reduce", {6'h00, tc[i][1:0]}, {6'h00, o_reduce_stage1, o_reduce_stage2});
         @(posedge i_sys_clk) #1;
         chk("reduce_end", 8'h00, {6'h00, o_reduce_stage1, o_reduce_stage2});
      end
   endtask
   // Absolute level against a 33 dB setpoint, exact threshold edges, then the clear modes
   task automatic t_absolute();
      logic [7:0] tc [6] = '{8'h0f, 8'h1f, 8'h00, 8'h21, 8'h07, 8'h27};
      wr(6'h1b, 8'h03);
      for (int i = 0; i < 6; i += 2) begin
         wr(6'h1c, tc[i]);
         smp(tc[i + 1]);
         chk("cs_low", 8'(i / 2 % 2), {7'h00, o_carrier_sense});
         chk("clear", 8'(1 - i / 2 % 2), {7'h00, o_channel_clear});
         smp(tc[i + 1] + 8'h01);
         chk("cs_high", 8'h01, {7'h00, o_carrier_sense});
         chk("clear", 8'h00, {7'h00, o_channel_clear});
      end
      // Receive flag toggles per mode so mode 2 shows clear while sense is high
      for (int m = 0; m < 4; m++) begin
         @(posedge i_sys_clk) begin
            i_channel_clear_select <= 2'(m);
            i_rx_packet_active <= m[0];
         end
         smp(8'h28);
         chk("clear_mode", 8'(!m[0]), {7'h00, o_channel_clear});
      end
      @(posedge i_sys_clk) begin
         i_channel_clear_select <= 2'h1;
         i_rx_packet_active <= 1'b0;
      end
      wr(6'h1c, 8'h08);
      smp(8'h7f);
      chk("cs_off", 8'h00, {7'h00, o_carrier_sense});
   endtask
   // Relative rise at exactly the step fires, one dB less does not
   task automatic t_relative();
      logic [7:0] st [3] = '{8'h06, 8'h0a, 8'h0e};
      for (int c = 1; c < 4; c++) begin
         for (int k = 0; k < 2; k++) begin
            wr(6'h1c, 8'h08);
            smp(8'hb0);
            chk("cs_base", 8'h00, {7'h00, o_carrier_sense});
            wr(6'h1c, {2'b00, 2'(c), 4'h8});
            // Idle sample right before the step, so the two arrive back to back
            @(posedge i_sys_clk) begin
               i_rssi_valid <= 1'b1;
               i_rssi <= 8'hb0;
            end
            smp(8'hb0 + st[c - 1] - 8'(k));
            chk("cs_rel", 8'(1 - k), {7'h00, o_carrier_sense});
         end
      end
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      @(posedge i_sys_clk) #1;
      t_reset();
      t_limits();
      t_reduce();
      t_absolute();
      t_relative();
      stop_test();
   end
endmodule // testbench
